/* File: hw/servo_cfg_pkg.sv */
package servo_cfg_pkg;

  // Byte addresses of the configuration table
  localparam logic [7:0] ADDR_MODEL_LO = 8'h00;
  localparam logic [7:0] ADDR_MODEL_HI = 8'h01;
  localparam logic [7:0] ADDR_FW_REV = 8'h02;
  localparam logic [7:0] ADDR_NODE_ID = 8'h03;
  localparam logic [7:0] ADDR_BIT_RATE = 8'h04;
  localparam logic [7:0] ADDR_REPLY_DELAY = 8'h05;
  localparam logic [7:0] ADDR_CW_LO = 8'h06;
  localparam logic [7:0] ADDR_CW_HI = 8'h07;
  localparam logic [7:0] ADDR_CCW_LO = 8'h08;
  localparam logic [7:0] ADDR_CCW_HI = 8'h09;
  localparam logic [7:0] ADDR_TEMP_CEIL = 8'h0B;
  localparam logic [7:0] ADDR_SUPPLY_FLOOR = 8'h0C;
  localparam logic [7:0] ADDR_SUPPLY_CEIL = 8'h0D;
  localparam logic [7:0] ADDR_TORQUE_LO = 8'h0E;
  localparam logic [7:0] ADDR_TORQUE_HI = 8'h0F;
  localparam logic [7:0] ADDR_REPLY_POLICY = 8'h10;
  localparam logic [7:0] ADDR_ALARM_MASK = 8'h11;
  localparam logic [7:0] ADDR_SHUTDOWN_MASK = 8'h12;
  localparam logic [7:0] ADDR_RAM_FIRST = 8'h18;
  localparam logic [7:0] ADDR_RUN_TORQUE_LO = 8'h22;
  localparam logic [7:0] ADDR_RUN_TORQUE_HI = 8'h23;
  localparam logic [7:0] ADDR_LOCK = 8'h2F;

  // Factory and power-up values
  localparam logic [7:0] RST_NODE_ID = 8'h01;
  localparam logic [7:0] RST_BIT_RATE = 8'h22;
  localparam logic [7:0] RST_REPLY_DELAY = 8'hFA;
  localparam logic [9:0] RST_CW = 10'h000;
  localparam logic [9:0] RST_CCW = 10'h3FF;
  localparam logic [7:0] RST_TEMP_CEIL = 8'h50;
  localparam logic [7:0] RST_SUPPLY_FLOOR = 8'h3C;
  localparam logic [7:0] RST_SUPPLY_CEIL = 8'hF0;
  localparam logic [9:0] RST_TORQUE = 10'h3FF;
  localparam logic [1:0] RST_REPLY_POLICY = 2'h2;
  localparam logic [7:0] RST_ALARM_MASK = 8'h24;
  localparam logic [7:0] RST_SHUTDOWN_MASK = 8'h24;

  // Legal value ranges and the broadcast identifier
  localparam logic [7:0] MAX_NODE_ID = 8'hFD;
  localparam logic [7:0] MAX_BYTE_SETTING = 8'hFE;
  localparam logic [7:0] MIN_TEMP_CEIL = 8'h0A;
  localparam logic [7:0] MAX_TEMP_CEIL = 8'h63;
  localparam logic [7:0] MIN_SUPPLY = 8'h32;
  localparam logic [7:0] MAX_SUPPLY = 8'hFA;
  localparam logic [7:0] MAX_HI_BYTE_10B = 8'h03;
  localparam logic [7:0] MAX_REPLY_POLICY = 8'h02;
  localparam logic [7:0] BROADCAST_ID = 8'hFE;

  // Error bit positions
  localparam int ERR_SUPPLY = 0;
  localparam int ERR_ANGLE = 1;
  localparam int ERR_HEAT = 2;
  localparam int ERR_RANGE = 3;
  localparam int ERR_CHECKSUM = 4;
  localparam int ERR_OVERLOAD = 5;
  localparam int ERR_INSTR = 6;

  // Timing
  localparam int CLOCK_HZ = 25_000_000;
  localparam int BIT_RATE_BASE_HZ = 2_000_000;
  localparam int REPLY_UNIT_NS = 2_000;
  localparam int CLOCK_PERIOD_NS = 1_000_000_000 / CLOCK_HZ;
  localparam int REPLY_UNIT_CYCLES = REPLY_UNIT_NS / CLOCK_PERIOD_NS;
  localparam logic [13:0] RATE_STEP = 14'(BIT_RATE_BASE_HZ / 1_000_000);
  localparam logic [13:0] RATE_CLK_MHZ = 14'(CLOCK_HZ / 1_000_000);
  localparam int ALARM_HOLD_MS = 2_000;
  localparam int ALARM_HOLD_CYCLES = ALARM_HOLD_MS * (CLOCK_HZ / 1_000);
  localparam int FLASH_HALF_MS = 250;
  localparam int FLASH_HALF_CYCLES = FLASH_HALF_MS * (CLOCK_HZ / 1_000);
  localparam int CNT_W = 26;

  // Kind of a finished instruction
  typedef enum logic [1:0] {
    INSTR_OTHER = 2'h0,
    INSTR_PING = 2'h1,
    INSTR_READ = 2'h2
  } instr_kind_t;

  // Reply scheduler, Gray along the path
  typedef enum logic [1:0] {
    RP_IDLE = 2'b00,
    RP_WAIT = 2'b01,
    RP_SEND = 2'b11
  } reply_state_t;

  // Monitored quantities from the sensing side
  typedef struct packed {
    logic [7:0] temperature;
    logic [7:0] supply;
    logic overload;
  } sense_t;

  // Whole state of the table
  typedef struct packed {
    logic [7:0] node_id;
    logic [7:0] bit_rate;
    logic [7:0] reply_delay;
    logic [9:0] cw_bound;
    logic [9:0] ccw_bound;
    logic [7:0] temp_ceil;
    logic [7:0] supply_floor;
    logic [7:0] supply_ceil;
    logic [9:0] torque_ceil;
    logic [1:0] reply_policy;
    logic [7:0] alarm_mask;
    logic [7:0] shutdown_mask;
    logic [9:0] run_torque;
    logic lock;
    logic shutdown;
    logic [7:0] events;
    logic [7:0] error;
    logic [CNT_W-1:0] hold_cnt;
    logic [CNT_W-1:0] flash_cnt;
    logic led;
    logic [13:0] rate_acc;
    logic rate_tick;
    reply_state_t rp_state;
    logic [7:0] rp_units;
    logic [7:0] rp_cyc;
    logic reply_go;
    logic id_match;
    logic [7:0] rd_data;
    logic [9:0] torque_out;
    logic free_run;
    logic nv_wr;
    logic [7:0] nv_addr;
    logic [7:0] nv_data;
  } table_state_t;

endpackage

/* File: hw/servo_cfg_table.sv */
`timescale 1ns/1ns
// Function
// - Power-up reloads volatile values; stored values persist
// - Read-only model code and firmware revision
// - Node identifier 0..253, default 1, matched
// - Bit rate is 2 MHz over byte+1
// - Bit-rate byte defaults to 34
// - Reply waits delay count times 2 us
// - Angle bounds are 10-bit positions
// - Over temperature sets error bit 2
// - Supply outside limits sets error bit 0
// - Torque 0..1023; zero means free running
// - Runtime torque limit copied at power-up
// - Torque is fraction of available torque
// - Reply policy none, reads only, all
// - Never reply to broadcast instructions
// - Always reply to ping addressed here
// - Alarm flashes on any masked error
// - Flashing stops two seconds after clearing
// - Fixed error bit assignments, bit 7 zero
// - Goal outside angle bounds sets bit 1
// - Masked error latches torque off until rewrite
// - Lock allows only host writes 24..35 (restore bypasses it), sticky
module servo_cfg_table #(
  parameter int ALARM_HOLD = servo_cfg_pkg::ALARM_HOLD_CYCLES,
  parameter int FLASH_HALF = servo_cfg_pkg::FLASH_HALF_CYCLES,
  parameter logic [15:0] MODEL_CODE = 16'h0A5A, // Arbitrary value
  parameter logic [7:0] FIRMWARE_REV = 8'h01 // Arbitrary value
) (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RSTN_I,
  // Table access from the packet layer
  input wire logic ACC_WR_I,
  input wire logic ACC_RD_I,
  input wire logic [7:0] ACC_ADDR_I,
  input wire logic [7:0] ACC_WDATA_I,
  output logic [7:0] RD_DATA_O,
  // Restore from and persist to non-volatile storage
  input wire logic RESTORE_I,
  input wire logic [7:0] RESTORE_ADDR_I,
  input wire logic [7:0] RESTORE_DATA_I,
  output logic NV_WR_O,
  output logic [7:0] NV_ADDR_O,
  output logic [7:0] NV_DATA_O,
  // Packet events and monitored quantities
  input wire logic PKT_START_I,
  input wire logic [7:0] PKT_ID_I,
  input wire logic INSTR_DONE_I,
  input wire servo_cfg_pkg::instr_kind_t INSTR_KIND_I,
  input wire logic INSTR_ERR_I,
  input wire logic CHECKSUM_ERR_I,
  input wire logic RANGE_ERR_I,
  input wire logic GOAL_WR_I,
  input wire logic [9:0] GOAL_POS_I,
  input wire servo_cfg_pkg::sense_t SENSE_I,
  // Results
  output logic ID_MATCH_O,
  output logic REPLY_GO_O,
  output logic BIT_TICK_O,
  output logic [7:0] ERROR_O,
  output logic ALARM_INDICATOR_MASK_O,
  output logic [9:0] TORQUE_LIMIT_O,
  output logic FREE_RUN_O
);
  import servo_cfg_pkg::*;

  // Counters share one width in the state record
  if (ALARM_HOLD < 1 || ALARM_HOLD >= 2 ** CNT_W || FLASH_HALF < 1
      || FLASH_HALF >= 2 ** CNT_W)
  begin : g_bad_count
    $error("Alarm counts do not fit the counter width");
  end

  table_state_t s;
  table_state_t next_s;

  // Byte view of the table for reads
  function automatic logic [7:0] read_byte(input table_state_t t, input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      ADDR_MODEL_LO: r = MODEL_CODE[7:0];
      ADDR_MODEL_HI: r = MODEL_CODE[15:8];
      ADDR_FW_REV: r = FIRMWARE_REV;
      ADDR_NODE_ID: r = t.node_id;
      ADDR_BIT_RATE: r = t.bit_rate;
      ADDR_REPLY_DELAY: r = t.reply_delay;
      ADDR_CW_LO: r = t.cw_bound[7:0];
      ADDR_CW_HI: r = {6'h00, t.cw_bound[9:8]};
      ADDR_CCW_LO: r = t.ccw_bound[7:0];
      ADDR_CCW_HI: r = {6'h00, t.ccw_bound[9:8]};
      ADDR_TEMP_CEIL: r = t.temp_ceil;
      ADDR_SUPPLY_FLOOR: r = t.supply_floor;
      ADDR_SUPPLY_CEIL: r = t.supply_ceil;
      ADDR_TORQUE_LO: r = t.torque_ceil[7:0];
      ADDR_TORQUE_HI: r = {6'h00, t.torque_ceil[9:8]};
      ADDR_REPLY_POLICY: r = {6'h00, t.reply_policy};
      ADDR_ALARM_MASK: r = t.alarm_mask;
      ADDR_SHUTDOWN_MASK: r = t.shutdown_mask;
      ADDR_RUN_TORQUE_LO: r = t.run_torque[7:0];
      ADDR_RUN_TORQUE_HI: r = {6'h00, t.run_torque[9:8]};
      ADDR_LOCK: r = {7'h00, t.lock};
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  // Whole next-state computation
  always_comb
  begin
    logic we;
    logic priv;
    logic [7:0] a;
    logic [7:0] d;
    logic ok;
    logic hit;
    logic bad_write;
    logic goal_bad;
    logic [7:0] level_err;
    logic [7:0] event_err;
    logic alarm_active;
    logic want_reply;
    logic [13:0] rate_lim;
    logic [13:0] rate_sum;
    we = 1'b0;
    priv = 1'b0;
    a = 8'h00;
    d = 8'h00;
    ok = 1'b0;
    hit = 1'b0;
    bad_write = 1'b0;
    goal_bad = 1'b0;
    level_err = 8'h00;
    event_err = 8'h00;
    alarm_active = 1'b0;
    want_reply = 1'b0;
    rate_lim = 14'h0000;
    rate_sum = 14'h0000;
    next_s = s;
    next_s.rate_tick = 1'b0;
    next_s.reply_go = 1'b0;
    next_s.nv_wr = 1'b0;

    // Restore has priority and bypasses the lock; range checks still drop bad values
    priv = RESTORE_I;
    a = priv ? RESTORE_ADDR_I : ACC_ADDR_I;
    d = priv ? RESTORE_DATA_I : ACC_WDATA_I;
    we = priv | ACC_WR_I;
    // Locked table only takes the runtime window
    ok = priv | ~s.lock | (a >= ADDR_RAM_FIRST && a <= ADDR_RUN_TORQUE_HI);
    hit = we & ok;

    if (ACC_RD_I)
    begin
      next_s.rd_data = read_byte(s, ACC_ADDR_I);
    end

    // Stores; each value outside its legal range is dropped, and flagged when it comes from a host write
    if (hit)
    begin
      case (a)
        ADDR_NODE_ID:
          if (d <= MAX_NODE_ID) next_s.node_id = d;
          else bad_write = 1'b1;
        ADDR_BIT_RATE:
          if (d <= MAX_BYTE_SETTING) next_s.bit_rate = d;
          else bad_write = 1'b1;
        ADDR_REPLY_DELAY:
          if (d <= MAX_BYTE_SETTING) next_s.reply_delay = d;
          else bad_write = 1'b1;
        ADDR_CW_LO: next_s.cw_bound[7:0] = d;
        ADDR_CW_HI:
          if (d <= MAX_HI_BYTE_10B) next_s.cw_bound[9:8] = d[1:0];
          else bad_write = 1'b1;
        ADDR_CCW_LO: next_s.ccw_bound[7:0] = d;
        ADDR_CCW_HI:
          if (d <= MAX_HI_BYTE_10B) next_s.ccw_bound[9:8] = d[1:0];
          else bad_write = 1'b1;
        ADDR_TEMP_CEIL:
          if (d >= MIN_TEMP_CEIL && d <= MAX_TEMP_CEIL) next_s.temp_ceil = d;
          else bad_write = 1'b1;
        ADDR_SUPPLY_FLOOR:
          if (d >= MIN_SUPPLY && d <= MAX_SUPPLY) next_s.supply_floor = d;
          else bad_write = 1'b1;
        ADDR_SUPPLY_CEIL:
          if (d >= MIN_SUPPLY && d <= MAX_SUPPLY) next_s.supply_ceil = d;
          else bad_write = 1'b1;
        ADDR_TORQUE_LO:
        begin
          next_s.torque_ceil[7:0] = d;
          if (priv) next_s.run_torque[7:0] = d;
        end
        ADDR_TORQUE_HI:
          if (d <= MAX_HI_BYTE_10B)
          begin
            next_s.torque_ceil[9:8] = d[1:0];
            if (priv) next_s.run_torque[9:8] = d[1:0];
          end
          else bad_write = 1'b1;
        ADDR_REPLY_POLICY:
          if (d <= MAX_REPLY_POLICY) next_s.reply_policy = d[1:0];
          else bad_write = 1'b1;
        ADDR_ALARM_MASK: next_s.alarm_mask = {1'b0, d[6:0]};
        ADDR_SHUTDOWN_MASK: next_s.shutdown_mask = {1'b0, d[6:0]};
        ADDR_RUN_TORQUE_LO:
        begin
          next_s.run_torque[7:0] = d;
          next_s.shutdown = 1'b0;
        end
        ADDR_RUN_TORQUE_HI:
          if (d <= MAX_HI_BYTE_10B)
          begin
            next_s.run_torque[9:8] = d[1:0];
            next_s.shutdown = 1'b0;
          end
          else bad_write = 1'b1;
        ADDR_LOCK:
          if (d[0]) next_s.lock = 1'b1;
        default: ; // Read-only and foreign bytes keep their value
      endcase
      // Accepted host writes below the runtime area go to storage
      if (!priv && a < ADDR_RAM_FIRST && a > ADDR_FW_REV && !bad_write)
      begin
        next_s.nv_wr = 1'b1;
        next_s.nv_addr = a;
        next_s.nv_data = d;
      end
    end

    // Error sources; events latch per packet, levels follow the inputs
    goal_bad = GOAL_WR_I && (GOAL_POS_I < s.cw_bound || GOAL_POS_I > s.ccw_bound);
    level_err[ERR_SUPPLY] = SENSE_I.supply < s.supply_floor
      || SENSE_I.supply > s.supply_ceil;
    level_err[ERR_HEAT] = SENSE_I.temperature > s.temp_ceil;
    level_err[ERR_OVERLOAD] = SENSE_I.overload;
    event_err[ERR_ANGLE] = goal_bad;
    event_err[ERR_RANGE] = RANGE_ERR_I | (ACC_WR_I & bad_write & ~priv);
    event_err[ERR_CHECKSUM] = CHECKSUM_ERR_I;
    event_err[ERR_INSTR] = INSTR_ERR_I;
    // New event wins over the packet-start clear
    next_s.events = (PKT_START_I ? 8'h00 : s.events) | event_err;
    next_s.error = (next_s.events | level_err) & 8'h7F;

    // Torque off latches until the runtime limit is rewritten
    if (|(next_s.error & s.shutdown_mask))
    begin
      next_s.shutdown = 1'b1;
    end
    // Output is a ratio of available torque, passed through unscaled
    next_s.torque_out = next_s.shutdown ? 10'h000 : next_s.run_torque;
    next_s.free_run = (next_s.torque_out == 10'h000);

    // Alarm flashing with a hold-off after recovery
    alarm_active = |(next_s.error & s.alarm_mask);
    if (alarm_active)
    begin
      next_s.hold_cnt = CNT_W'(ALARM_HOLD);
    end
    else if (s.hold_cnt != '0)
    begin
      next_s.hold_cnt = s.hold_cnt - 1'b1;
    end
    if (alarm_active || s.hold_cnt != '0)
    begin
      if (s.flash_cnt == '0)
      begin
        next_s.flash_cnt = CNT_W'(FLASH_HALF - 1);
        next_s.led = ~s.led;
      end
      else
      begin
        next_s.flash_cnt = s.flash_cnt - 1'b1;
      end
    end
    else
    begin
      next_s.flash_cnt = '0;
      next_s.led = 1'b0;
    end

    // Bit-rate tick: half-cycle accumulator gives 12.5 cycles per unit
    rate_lim = RATE_CLK_MHZ * ({6'h00, s.bit_rate} + 14'h0001);
    rate_sum = s.rate_acc + RATE_STEP;
    if (rate_sum >= rate_lim)
    begin
      // A lowered divisor leaves the sum far above the limit; restart, no tick burst
      next_s.rate_acc = (rate_sum - rate_lim < rate_lim) ? rate_sum - rate_lim : 14'h0000;
      next_s.rate_tick = 1'b1;
    end
    else
    begin
      next_s.rate_acc = rate_sum;
    end

    // Address filter for the packet layer
    next_s.id_match = (PKT_ID_I == s.node_id) || (PKT_ID_I == BROADCAST_ID);

    // Reply decision and delay
    want_reply = (PKT_ID_I == s.node_id) && (PKT_ID_I != BROADCAST_ID)
      && (INSTR_KIND_I == INSTR_PING
      || s.reply_policy == 2'h2
      || (s.reply_policy == 2'h1 && INSTR_KIND_I == INSTR_READ));
    case (s.rp_state)
      RP_IDLE:
        if (INSTR_DONE_I && want_reply)
        begin
          next_s.rp_state = RP_WAIT;
          next_s.rp_units = s.reply_delay;
          next_s.rp_cyc = 8'(REPLY_UNIT_CYCLES - 1);
        end
      RP_WAIT:
        if (s.rp_units == 8'h00)
        begin
          next_s.rp_state = RP_SEND;
        end
        else if (s.rp_cyc == 8'h00)
        begin
          next_s.rp_units = s.rp_units - 8'h01;
          next_s.rp_cyc = 8'(REPLY_UNIT_CYCLES - 1);
        end
        else
        begin
          next_s.rp_cyc = s.rp_cyc - 8'h01;
        end
      RP_SEND:
      begin
        next_s.reply_go = 1'b1;
        next_s.rp_state = RP_IDLE;
      end
      default: next_s.rp_state = RP_IDLE;
    endcase
  end

  // State register; reset gives the power-up image
  always_ff @(posedge CLOCK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      s <= '0;
      s.node_id <= RST_NODE_ID;
      s.bit_rate <= RST_BIT_RATE;
      s.reply_delay <= RST_REPLY_DELAY;
      s.cw_bound <= RST_CW;
      s.ccw_bound <= RST_CCW;
      s.temp_ceil <= RST_TEMP_CEIL;
      s.supply_floor <= RST_SUPPLY_FLOOR;
      s.supply_ceil <= RST_SUPPLY_CEIL;
      s.torque_ceil <= RST_TORQUE;
      s.run_torque <= RST_TORQUE;
      s.torque_out <= RST_TORQUE;
      s.reply_policy <= RST_REPLY_POLICY;
      s.alarm_mask <= RST_ALARM_MASK;
      s.shutdown_mask <= RST_SHUTDOWN_MASK;
      s.rp_state <= RP_IDLE;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Outputs straight from the state record
  assign RD_DATA_O = s.rd_data;
  assign NV_WR_O = s.nv_wr;
  assign NV_ADDR_O = s.nv_addr;
  assign NV_DATA_O = s.nv_data;
  assign ID_MATCH_O = s.id_match;
  assign REPLY_GO_O = s.reply_go;
  assign BIT_TICK_O = s.rate_tick;
  assign ERROR_O = s.error;
  assign ALARM_INDICATOR_MASK_O = s.led;
  assign TORQUE_LIMIT_O = s.torque_out;
  assign FREE_RUN_O = s.free_run;

endmodule

/* File: dv/servo_cfg_table_checker.sv */
`timescale 1ns/1ns
module servo_cfg_table_checker (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RSTN_I,
  // Watched inputs
  input wire logic ACC_WR_I,
  input wire logic [7:0] ACC_ADDR_I,
  input wire logic [7:0] ACC_WDATA_I,
  input wire logic CHECKSUM_ERR_I,
  input wire logic INSTR_ERR_I,
  // Watched outputs
  input wire logic NV_WR_O,
  input wire logic [7:0] NV_ADDR_O,
  input wire logic [7:0] NV_DATA_O,
  input wire logic REPLY_GO_O,
  input wire logic [7:0] ERROR_O,
  input wire logic [9:0] TORQUE_LIMIT_O,
  input wire logic FREE_RUN_O
);
  import servo_cfg_pkg::*;

  // One domain, so clock and reset are given once
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RSTN_I);

  // Host write and its persisted echo one cycle later
  sequence s_ro_write;
    ACC_WR_I && ACC_ADDR_I <= ADDR_FW_REV;
  endsequence
  sequence s_nv_echo;
    $past(ACC_WR_I) && NV_ADDR_O == $past(ACC_ADDR_I) && NV_DATA_O == $past(ACC_WDATA_I);
  endsequence

  a_nv_echo: assert property (NV_WR_O |-> s_nv_echo)
    else $error("persist pulse without matching host write");
  a_nv_range: assert property (NV_WR_O |-> NV_ADDR_O inside {[8'h03:8'h17]})
    else $error("persist pulse outside stored area");
  a_ro_ignored: assert property (s_ro_write |=> !NV_WR_O)
    else $error("read-only write was persisted");
  a_bit7_zero: assert property (!ERROR_O[7])
    else $error("error bit 7 set");
  a_checksum_flag: assert property (CHECKSUM_ERR_I |=> ERROR_O[ERR_CHECKSUM])
    else $error("checksum event not flagged");
  a_instr_flag: assert property (INSTR_ERR_I |=> ERROR_O[ERR_INSTR])
    else $error("instruction event not flagged");
  a_free_run_tie: assert property (FREE_RUN_O == (TORQUE_LIMIT_O == 10'h000))
    else $error("free run disagrees with torque limit");
  a_reset_torque: assert property ($rose(RSTN_I) |-> TORQUE_LIMIT_O == 10'h3FF)
    else $error("torque limit not loaded at power-up");
  a_reply_pulse: assert property (REPLY_GO_O |=> !REPLY_GO_O)
    else $error("reply strobe longer than one cycle");
endmodule

bind servo_cfg_table servo_cfg_table_checker chk_u (
  .CLOCK_I(CLOCK_I), .RSTN_I(RSTN_I), .ACC_WR_I(ACC_WR_I), .ACC_ADDR_I(ACC_ADDR_I),
  .ACC_WDATA_I(ACC_WDATA_I), .CHECKSUM_ERR_I(CHECKSUM_ERR_I), .INSTR_ERR_I(INSTR_ERR_I),
  .NV_WR_O(NV_WR_O), .NV_ADDR_O(NV_ADDR_O), .NV_DATA_O(NV_DATA_O), .REPLY_GO_O(REPLY_GO_O),
  .ERROR_O(ERROR_O), .TORQUE_LIMIT_O(TORQUE_LIMIT_O), .FREE_RUN_O(FREE_RUN_O)
);

/* File: dv/host_packet_model.sv */
`timescale 1ns/1ns
module host_packet_model (
  // Clock
  input wire logic clock_i,
  // Table access
  input wire logic [7:0] rd_data_i,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  // Idle bus from time zero
  initial
  begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end

  // Lines are inverted once released, so stale values never look valid
  task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i);
    wr_o = 1'b1;
    addr_o = a;
    wdata_o = d;
    @(negedge clock_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask

  // Data is taken one cycle after the request edge
  task automatic read_byte(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock_i);
    rd_o = 1'b1;
    addr_o = a;
    @(negedge clock_i);
    rd_o = 1'b0;
    addr_o = ~a;
    d = rd_data_i;
  endtask

  // Both halves in one packet, low byte first
  task automatic write_pair(input logic [7:0] a, input logic [15:0] v);
    write_byte(a, v[7:0]);
    write_byte(a + 8'h01, v[15:8]);
  endtask
endmodule

/* File: dv/servo_nonvolatile_config_table_tb_top.sv */
`timescale 1ns/1ns
module servo_nonvolatile_config_table_tb_top;
  import servo_cfg_pkg::*;
  localparam int HOLD = 40;
  localparam int HALF = 4;
  localparam logic [15:0] MODEL = 16'h3C69; // Arbitrary value
  localparam logic [7:0] FWREV = 8'h07; // Arbitrary value
  localparam logic [7:0] DEF [0:18] = '{MODEL[7:0], MODEL[15:8], FWREV, 8'h01, 8'h22, 8'hFA,
    8'h00, 8'h00, 8'hFF, 8'h03, 8'h00, 8'h50, 8'h3C, 8'hF0, 8'hFF, 8'h03, 8'h02, 8'h24, 8'h24};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr, rd, nv_wr, id_match, reply_go, tick, led, free_run, prev;
  logic [7:0] addr, wdata, rd_out, rdata, nv_addr, nv_data, err;
  logic [9:0] tlim;
  logic restore = 1'b0;
  logic [7:0] rs_addr = 8'h00;
  logic [7:0] rs_data = 8'h00;
  logic pkt_start = 1'b0, done = 1'b0, ierr = 1'b0, cerr = 1'b0, rerr = 1'b0, goal_wr = 1'b0;
  logic [7:0] pkt_id = 8'h00;
  logic [9:0] goal = 10'h000;
  instr_kind_t kind = INSTR_OTHER;
  sense_t sense = '{8'h00, 8'h64, 1'b0};
  int n_fail = 0, samples_checked = 0, seed = 32'h868B96FC;
  int a, d, k, got, e, locked;
  int rates [3] = '{0, 1, 9};
  logic [7:0] mem [0:255];
  logic [8:0] nvs [0:255];

  servo_cfg_table #(.ALARM_HOLD(HOLD), .FLASH_HALF(HALF), .MODEL_CODE(MODEL),
    .FIRMWARE_REV(FWREV)) dut_u (
    .CLOCK_I(clk), .RSTN_I(rst_n), .ACC_WR_I(wr), .ACC_RD_I(rd), .ACC_ADDR_I(addr),
    .ACC_WDATA_I(wdata), .RD_DATA_O(rd_out), .RESTORE_I(restore), .RESTORE_ADDR_I(rs_addr),
    .RESTORE_DATA_I(rs_data), .NV_WR_O(nv_wr), .NV_ADDR_O(nv_addr), .NV_DATA_O(nv_data),
    .PKT_START_I(pkt_start), .PKT_ID_I(pkt_id), .INSTR_DONE_I(done), .INSTR_KIND_I(kind),
    .INSTR_ERR_I(ierr), .CHECKSUM_ERR_I(cerr), .RANGE_ERR_I(rerr), .GOAL_WR_I(goal_wr),
    .GOAL_POS_I(goal), .SENSE_I(sense), .ID_MATCH_O(id_match), .REPLY_GO_O(reply_go),
    .BIT_TICK_O(tick), .ERROR_O(err), .ALARM_INDICATOR_MASK_O(led), .TORQUE_LIMIT_O(tlim),
    .FREE_RUN_O(free_run));

  host_packet_model host_u (.clock_i(clk), .rd_data_i(rd_out), .wr_o(wr), .rd_o(rd),
    .addr_o(addr), .wdata_o(wdata));

  // 25 MHz clock
  initial
  begin
    forever #20 clk = ~clk;
  end

  // Storage side: last persisted byte per address, sampled away from the launch edge
  always @(negedge clk)
    if (nv_wr === 1'b1)
      nvs[nv_addr] = {1'b1, nv_data};

  task automatic chk(input logic [15:0] got_v, input logic [15:0] exp_v, input string what);
    samples_checked++;
    if (got_v !== exp_v)
    begin
      n_fail++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got_v, exp_v);
    end
  endtask

  // 0 ignored, 1 stored, 2 refused as out of range
  function automatic int legal(input int ad, input int dv);
    case (ad)
      3: return (dv <= 253) ? 1 : 2;
      4, 5: return (dv < 255) ? 1 : 2;
      6, 8, 14, 17, 18, 34: return 1;
      7, 9, 15, 35: return (dv <= 3) ? 1 : 2;
      11: return (dv >= 10 && dv <= 99) ? 1 : 2;
      12, 13: return (dv >= 50 && dv <= 250) ? 1 : 2;
      16: return (dv <= 2) ? 1 : 2;
      default: return 0;
    endcase
  endfunction

  // Write through the host and track it in the model
  task automatic wrm(input int ad, input int dv);
    host_u.write_byte(ad[7:0], dv[7:0]);
    if (locked == 0 || (ad >= 24 && ad <= 35))
      if (legal(ad, dv) == 1)
        mem[ad] = (ad == 17 || ad == 18) ? 8'(dv & 127) : 8'(dv);
    if (ad == 47 && dv[0])
      locked = 1;
  endtask

  // Keep the stored area when the power cycle is followed by a restore
  task automatic do_reset(input int keep);
    @(negedge clk) rst_n = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    locked = 0;
    for (int i = 0; i < 256; i++)
      if (keep == 0)
        mem[i] = (i < 19) ? DEF[i] : 8'h00;
    mem[34] = mem[14];
    mem[35] = mem[15];
  endtask

  task automatic check_table;
    for (int i = 0; i < 36; i++)
      if (i < 19 || i > 33)
      begin
        host_u.read_byte(i[7:0], rdata);
        chk(rdata, mem[i], "table read");
      end
  endtask

  task automatic toggles(input int n);
    k = 0;
    prev = led;
    repeat (n)
    begin
      @(negedge clk);
      if (led !== prev)
        k++;
      prev = led;
    end
  endtask

  task automatic reply_case(input int pol, input logic [7:0] id, input instr_kind_t kd,
    input int yes);
    wrm(16, pol);
    @(negedge clk) pkt_id = id;
    @(negedge clk) done = 1'b1;
    kind = kd;
    @(negedge clk) done = 1'b0;
    chk(id_match, 16'(id == 8'h01 || id == 8'hFE), "id match");
    got = 0;
    for (int j = 1; j <= 60; j++)
    begin
      @(posedge clk);
      #1;
      if (reply_go === 1'b1 && got == 0)
        got = j;
    end
    e = yes ? mem[5] * REPLY_UNIT_CYCLES + 2 : 0;
    chk(got[15:0], e[15:0], "reply cycle");
  endtask

  task report_and_stop;
    $display("checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    report_and_stop();
  end

  initial
  begin
    do_reset(0);
    check_table();
    chk(tlim, 10'h3FF, "torque copy");
    // Random writes, each refused value flagged and left unstored
    repeat (40)
    begin
      a = {$random(seed)} % 19;
      d = {$random(seed)} % 256;
      @(negedge clk) pkt_start = 1'b1;
      @(negedge clk) pkt_start = 1'b0;
      wrm(a, d);
      repeat (2) @(negedge clk);
      chk(err[ERR_RANGE], 16'(legal(a, d) == 2), "range flag");
      host_u.read_byte(a[7:0], rdata);
      chk(rdata, mem[a], "readback");
    end
    wrm(12, 50);
    wrm(13, 250);
    wrm(18, 0);
    // Power cycle, then reload what storage holds; stale limits must not latch shutdown
    do_reset(1);
    for (int i = 3; i < 24; i++)
      if (nvs[i][8] === 1'b1)
      begin
        @(negedge clk) restore = 1'b1;
        rs_addr = 8'(i);
        rs_data = nvs[i][7:0];
        @(negedge clk) restore = 1'b0;
        rs_data = ~rs_data;
      end
    check_table();
    chk(tlim, {mem[15][1:0], mem[14]}, "torque restored");
    chk(free_run, 16'({mem[15][1:0], mem[14]} == 10'h000), "free run");
    // Locked table takes only the runtime window
    wrm(47, 1);
    wrm(3, 9);
    wrm(34, 16);
    for (int i = 3; i <= 34; i += 31)
    begin
      host_u.read_byte(i[7:0], rdata);
      chk(rdata, mem[i], "locked write");
    end
    do_reset(0);
    // Every error source at once, then recovery
    wrm(7, 1);
    @(negedge clk) sense = '{8'h51, 8'h28, 1'b1};
    {cerr, ierr, rerr, goal_wr, goal} = {4'hF, 10'h050};
    @(negedge clk) {cerr, ierr, rerr, goal_wr} = 4'h0;
    @(negedge clk);
    chk(err, 8'h7F, "error byte");
    chk(tlim, 10'h000, "shutdown");
    toggles(20);
    chk(16'(k >= 2), 16'h0001, "flashing");
    @(negedge clk) sense = '{8'h00, 8'h64, 1'b0};
    pkt_start = 1'b1;
    @(negedge clk) pkt_start = 1'b0;
    @(negedge clk);
    chk(err, 8'h00, "errors cleared");
    toggles(20);
    chk(16'(k >= 2), 16'h0001, "flash hold");
    repeat (HOLD + HALF) @(negedge clk);
    chk(led, 1'b0, "flash stop");
    chk(tlim, 10'h000, "shutdown kept");
    host_u.write_pair(8'h22, 16'h0200);
    @(negedge clk);
    chk(tlim, 10'h200, "torque rewritten");
    // Reply policy, broadcast and ping cases with a short delay
    wrm(5, 1);
    reply_case(0, 8'h01, INSTR_READ, 0);
    reply_case(0, 8'h01, INSTR_PING, 1);
    reply_case(1, 8'h01, INSTR_READ, 1);
    reply_case(1, 8'h01, INSTR_OTHER, 0);
    reply_case(2, 8'h01, INSTR_OTHER, 1);
    reply_case(2, 8'hFE, INSTR_PING, 0);
    reply_case(2, 8'h02, INSTR_PING, 0);
    // Bit-rate strobe count over a fixed span
    foreach (rates[i])
    begin
      wrm(4, rates[i]);
      k = 0;
      repeat (500)
      begin
        @(negedge clk);
        if (tick === 1'b1)
          k++;
      end
      e = 500 * (BIT_RATE_BASE_HZ / 1000) / ((CLOCK_HZ / 1000) * (rates[i] + 1));
      chk(16'(k >= e - 1 && k <= e + 1), 16'h0001, "bit rate");
    end
    report_and_stop();
  end
endmodule
